//--- logic/lcr_pkg.sv
package lcr_pkg;
  localparam int          LCR_DATA_W       = 32;
  localparam int          LCR_ADDR_W       = 32;
  localparam int          LCR_FIRST_LANE   = 3;
  localparam int          LCR_NUM_LANES    = 3;
  localparam int          LCR_TX_W_DEF     = 32;
  localparam int          LCR_CNT_W        = 2;

  localparam logic [31:0] LCR_LANE3_OFS    = 32'h0000_0010;
  localparam logic [31:0] LCR_LANE4_OFS    = 32'h0000_0014;
  localparam logic [31:0] LCR_LANE5_OFS    = 32'h0000_0018;

  localparam int          LCR_INVERT_POS   = 0;
  localparam int          LCR_POWER_POS    = 1;
  localparam int          LCR_SPARE_LSB    = 2;
  localparam int          LCR_SPARE_MSB    = 9;
  localparam int          LCR_FIELD_W      = 10;
  localparam logic [9:0]  LCR_CTRL_RESET   = 10'h000;

  localparam logic [1:0]  LCR_HTRANS_NSEQ  = 2'h2;
  localparam logic [2:0]  LCR_HSIZE_WORD   = 3'h2;
  localparam logic        LCR_HRESP_OKAY   = 1'b0;
endpackage

//--- logic/lcr_lane_reg.sv
`timescale 1ns/1ps
module lcr_lane_reg
  import lcr_pkg::*;
#(
  parameter int TX_W = LCR_TX_W_DEF
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   wr_en,
  input  wire logic [LCR_FIELD_W-1:0] wr_data,
  input  wire logic [TX_W-1:0]        tx_data_in,
  output logic      [LCR_FIELD_W-1:0] ctrl_q,
  output logic      [TX_W-1:0]        tx_data_out_q
);

  // Only bits 9:0 exist; bits 31:10 are never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= LCR_CTRL_RESET;
    end else if (wr_en) begin
      ctrl_q <= wr_data;
    end
  end

  // One register stage keeps the inverted path aligned with the plain path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data_out_q <= '0;
    end else begin
      tx_data_out_q <= tx_data_in ^ {TX_W{ctrl_q[LCR_INVERT_POS]}};
    end
  end

endmodule // lcr_lane_reg

//--- logic/lcr_lane_control_registers.sv
// Functional notes
// - Power-down bit 1 drives lane power vector
// - Power bit: 0 normal, 1 off; reset 0
// - Vector gives transport layer its active lanes
// - Invert bit 0 inverts lane transmit data
// - Bits 9:2 spare field, read/write, reset 0
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module lcr_lane_control_registers
  import lcr_pkg::*;
#(
  parameter int TX_W = LCR_TX_W_DEF
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [LCR_ADDR_W-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [LCR_DATA_W-1:0] hwdata,
  input  wire logic                  hready,
  output logic      [LCR_DATA_W-1:0] hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [TX_W-1:0]       lane3_tx_data_in,
  input  wire logic [TX_W-1:0]       lane4_tx_data_in,
  input  wire logic [TX_W-1:0]       lane5_tx_data_in,
  output logic      [TX_W-1:0]       lane3_tx_data_out,
  output logic      [TX_W-1:0]       lane4_tx_data_out,
  output logic      [TX_W-1:0]       lane5_tx_data_out,
  output logic      [5:3]            lane_power_off,
  output logic      [LCR_CNT_W-1:0]  active_lane_count
);

  logic [LCR_NUM_LANES-1:0]  sel_lane;
  logic                      addr_valid;
  logic [LCR_NUM_LANES-1:0]  wr_pend_q;
  logic [LCR_NUM_LANES-1:0]  wr_en;
  logic [LCR_FIELD_W-1:0]    lane3_ctrl_q;
  logic [LCR_FIELD_W-1:0]    lane4_ctrl_q;
  logic [LCR_FIELD_W-1:0]    lane5_ctrl_q;
  logic [LCR_FIELD_W-1:0]    rd_field;
  logic [LCR_NUM_LANES-1:0]  power_bits;
  logic [LCR_CNT_W-1:0]      active_d;

  assign addr_valid = hsel && hready && (htrans == LCR_HTRANS_NSEQ);

  always_comb begin
    sel_lane    = '0;
    sel_lane[0] = (haddr == LCR_LANE3_OFS);
    sel_lane[1] = (haddr == LCR_LANE4_OFS);
    sel_lane[2] = (haddr == LCR_LANE5_OFS);
  end

  // Write is latched in the address phase and committed with hwdata
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= '0;
    end else if (addr_valid && hwrite && hsize == LCR_HSIZE_WORD) begin
      wr_pend_q <= sel_lane;
    end else begin
      wr_pend_q <= '0;
    end
  end

  assign wr_en = wr_pend_q;

  lcr_lane_reg #(.TX_W(TX_W)) u_lane3 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .wr_en         (wr_en[0]),
    .wr_data       (hwdata[LCR_FIELD_W-1:0]),
    .tx_data_in    (lane3_tx_data_in),
    .ctrl_q        (lane3_ctrl_q),
    .tx_data_out_q (lane3_tx_data_out)
  );

  lcr_lane_reg #(.TX_W(TX_W)) u_lane4 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .wr_en         (wr_en[1]),
    .wr_data       (hwdata[LCR_FIELD_W-1:0]),
    .tx_data_in    (lane4_tx_data_in),
    .ctrl_q        (lane4_ctrl_q),
    .tx_data_out_q (lane4_tx_data_out)
  );

  lcr_lane_reg #(.TX_W(TX_W)) u_lane5 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .wr_en         (wr_en[2]),
    .wr_data       (hwdata[LCR_FIELD_W-1:0]),
    .tx_data_in    (lane5_tx_data_in),
    .ctrl_q        (lane5_ctrl_q),
    .tx_data_out_q (lane5_tx_data_out)
  );

  always_comb begin
    rd_field = '0;
    if (sel_lane[0]) begin
      rd_field = lane3_ctrl_q;
    end else if (sel_lane[1]) begin
      rd_field = lane4_ctrl_q;
    end else if (sel_lane[2]) begin
      rd_field = lane5_ctrl_q;
    end
  end

  // Read data is sampled in the address phase; safe since the master
  // always separates transfers by an idle data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_valid && !hwrite) begin
      hrdata <= {{(LCR_DATA_W-LCR_FIELD_W){1'b0}}, rd_field};
    end
  end

  // Zero wait states, always OKAY; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= LCR_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= LCR_HRESP_OKAY;
    end
  end

  assign power_bits = {lane5_ctrl_q[LCR_POWER_POS],
                       lane4_ctrl_q[LCR_POWER_POS],
                       lane3_ctrl_q[LCR_POWER_POS]};

  // Follows the register by one cycle; the receive reset mask
  // outside takes this vector as is
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lane_power_off <= '0;
    end else begin
      lane_power_off <= power_bits;
    end
  end

  always_comb begin
    active_d = LCR_CNT_W'(LCR_NUM_LANES);
    for (int i = 0; i < LCR_NUM_LANES; i++) begin
      if (power_bits[i]) begin
        active_d = active_d - 2'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_lane_count <= LCR_CNT_W'(LCR_NUM_LANES);
    end else begin
      active_lane_count <= active_d;
    end
  end

endmodule // lcr_lane_control_registers

//--- tb/lcr_sva.sv
`timescale 1ns/1ps
module lcr_sva #(parameter int TX_W = 32) (
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic            hready,
  input wire logic            hwrite,
  input wire logic [1:0]      htrans,
  input wire logic [2:0]      hsize,
  input wire logic [31:0]     haddr,
  input wire logic [31:0]     hwdata,
  input wire logic [31:0]     hrdata,
  input wire logic [TX_W-1:0] lane3_tx_data_in,
  input wire logic [TX_W-1:0] lane3_tx_data_out,
  input wire logic [5:3]      lane_power_off,
  input wire logic [1:0]      active_lane_count
);
  logic       wr_q, rd_q, hit_q;
  logic [9:0] m3_q;
  // Bus-side shadow of lane 3 only, to keep the checker small
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, rd_q, hit_q, m3_q} <= 13'h0;
    end else begin
      wr_q  <= hsel && hready && htrans == 2'h2 && hwrite && hsize == 3'h2;
      rd_q  <= hsel && hready && htrans == 2'h2 && !hwrite;
      hit_q <= haddr == 32'h10;
      if (wr_q && hit_q) m3_q <= hwdata[9:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_power_follow: assert property (
    wr_q && hit_q |-> ##2 lane_power_off[3] == $past(hwdata[1], 2))
    else $error("power bit");
  chk_reset_state: assert property (
    $rose(hresetn) |-> lane_power_off == 3'h0 && active_lane_count == 2'h3)
    else $error("reset state");
  chk_lane_count: assert property (
    active_lane_count == 2'(3 - $countones(lane_power_off)))
    else $error("lane count");
  chk_tx_invert: assert property ($past(hresetn) |->
    lane3_tx_data_out == ($past(lane3_tx_data_in) ^ {TX_W{$past(m3_q[0])}}))
    else $error("tx data");
  chk_read_value: assert property (
    rd_q && hit_q |-> hrdata[9:0] == $past(m3_q)) else $error("read data");
  chk_upper_zero: assert property (
    rd_q |-> hrdata[31:10] == 22'h0) else $error("upper bits");
  cover property (wr_q && hit_q);
  cover property (rd_q && !hit_q);
  cover property (lane_power_off == 3'h7);
endmodule // lcr_sva
bind lcr_lane_control_registers lcr_sva #(.TX_W(TX_W)) lcr_sva_i (.*);

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench import lcr_pkg::*;;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        hready, hresp;
  logic [1:0]  htrans = 2'h0, cnt;
  logic [2:0]  hsize = 3'h2, pwr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, din = 32'h0, a, r;
  logic [31:0] hrdata, o3, o4, o5;
  int          err_total = 0, n_tests = 0;
  lcr_lane_control_registers lcr_lane_control_registers_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp,
    .lane3_tx_data_in(din), .lane4_tx_data_in(din),
    .lane5_tx_data_in(~din), .lane3_tx_data_out(o3),
    .lane4_tx_data_out(o4), .lane5_tx_data_out(o5),
    .lane_power_off(pwr), .active_lane_count(cnt));
  initial forever #4 hclk = ~hclk;
  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Hreadyout is always high, but the master still waits on it
  task automatic xfer(logic [31:0] ad, logic w, logic [2:0] z, logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= ad;
    hwrite <= w;
    hsize  <= z;
    htrans <= LCR_HTRANS_NSEQ;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    r = hrdata;
  endtask
  task automatic rd(logic [31:0] ad, logic [31:0] e, string s);
    xfer(ad, 1'h0, 3'h2, 32'h0);
    chk(s, e, r);
  endtask
  initial begin
    #10000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int i = 0; i < 3; i++) begin
      a = LCR_LANE3_OFS + 32'(4 * i);
      rd(a, 32'h0, "reset");
      xfer(a, 1'h1, 3'h2, 32'hffff_ffff);
      rd(a, 32'h3ff, "rw");
    end
    din <= 32'h1234_5678;
    repeat (2) @(posedge hclk);
    chk("off", 32'h7, pwr);
    chk("resp", 32'h0, hresp);
    chk("count", 32'h0, cnt);
    chk("tx3", 32'hedcb_a987, o3);
    chk("tx5", 32'h1234_5678, o5);
    xfer(LCR_LANE4_OFS, 1'h1, 3'h2, 32'h0000_02a8);
    repeat (2) @(posedge hclk);
    chk("off4", 32'h5, pwr);
    chk("count4", 32'h1, cnt);
    chk("tx4", 32'h1234_5678, o4);
    rd(LCR_LANE4_OFS, 32'h2a8, "spare");
    xfer(LCR_LANE3_OFS, 1'h1, 3'h0, 32'h0);
    rd(LCR_LANE3_OFS, 32'h3ff, "byte");
    xfer(32'h0000_001c, 1'h1, 3'h2, 32'hffff_ffff);
    rd(32'h0000_001c, 32'h0, "unmapped");
    // Reset in mid-run must clear the lane registers that were written
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("rst_off", 32'h0, pwr);
    chk("rst_count", 32'h3, cnt);
    rd(LCR_LANE4_OFS, 32'h0, "rst_reg");
    end_sim();
  end
endmodule // testbench
